// File: hw/nei_defs.svh
`ifndef NEI_DEFS_SVH
`define NEI_DEFS_SVH

// ----------------------------------------
// Pending register layout
// ----------------------------------------
`define NEI_PEND_NMI_BIT   7
`define NEI_PEND_CLR_MASK  8'h7f
`define NEI_PEND_RESET     8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define NEI_STATE_TIME_NS  10
`define NEI_CLK_PERIOD_NS  5
`define NEI_STATE_CYCLES   ((`NEI_STATE_TIME_NS + `NEI_CLK_PERIOD_NS - 1) / `NEI_CLK_PERIOD_NS)

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NEI_PIN_COUNT      32
`define NEI_SRC_COUNT      4

`endif

// File: hw/nei_pkg.sv
`include "nei_defs.svh"

package nei_pkg;

	// ----------------------------------------
	// Exception sources, highest rank first
	// ----------------------------------------
	typedef enum logic [1:0] {
		NEI_SRC_TRAP   = 2'h0,
		NEI_SRC_UNIMPL = 2'h1,
		NEI_SRC_NMI    = 2'h2,
		NEI_SRC_OTHER  = 2'h3
	} nei_src_t;

	// ----------------------------------------
	// Power mode, Gray along run-idle path
	// ----------------------------------------
	typedef enum logic [1:0] {
		NEI_MODE_RUN   = 2'h0,
		NEI_MODE_IDLE  = 2'h1,
		NEI_MODE_STBY  = 2'h3,
		NEI_MODE_PDOWN = 2'h2
	} nei_mode_t;

	// ----------------------------------------
	// Grouped request lines from the core
	// ----------------------------------------
	typedef struct packed {
		logic trap;
		logic unimpl;
		logic other;
	} nei_req_t;

	typedef struct packed {
		logic     valid;
		nei_src_t src;
	} nei_grant_t;

endpackage : nei_pkg

// File: hw/nei_top.sv
// Operation
// - A rising edge on the interrupt pin raises a nonmaskable request.
// - Nonmaskable ranks below trap and unimplemented opcode, above all else.
// - Pin high through reset leaves the request pending afterwards.
// - A rising edge in idle wakes the device toward the service routine.
// - Strap sampled at reset release; high there enters isolation mode.
// - Isolation floats every pin except ready, reset, strap and interrupt.
// - Isolation ends only through reset with the strap low at release.
// - Reset in powerdown, standby or idle returns to normal operation.
`include "nei_defs.svh"

module nei_top
	import nei_pkg::*;
(
	// Clock and reset
	input  wire logic                          REF_CLK_IN,
	input  wire logic                          RESET_IN,
	// Interrupt and strap pins
	input  wire logic                          NMI_PIN_IN,
	input  wire logic                          EMULATION_ISOLATE_STRAP_IN,
	// Core side
	input  wire nei_req_t                      REQ_IN,
	input  wire nei_mode_t                     MODE_REQ_IN,
	input  wire logic                          MODE_REQ_VALID_IN,
	input  wire logic                          PEND_WR_IN,
	input  wire logic [7:0]                    PEND_WR_DATA_IN,
	input  wire logic [`NEI_PIN_COUNT-1:0]     PIN_OE_CORE_IN,
	// Results
	output logic                               NMI_PENDING_OUT,
	output logic [7:0]                         INTERRUPT_PENDING_REG_HI_OUT,
	output nei_grant_t                         GRANT_OUT,
	output logic                               WAKE_OUT,
	output nei_mode_t                          MODE_OUT,
	output logic                               ISOLATE_OUT,
	output logic [`NEI_PIN_COUNT-1:0]          PIN_OE_OUT
);

	// ----------------------------------------
	// Sampling and edge detect
	// ----------------------------------------
	// Pin is synchronous, but a second sample gives the edge compare
	logic       nmi_s1_ff;
	logic       nmi_s2_ff;
	logic       nmi_rise;
	logic [7:0] pend_ff;
	logic       rst_d_ff;
	logic       isolate_ff;
	nei_mode_t  mode_ff;
	nei_mode_t  nxt_mode;
	nei_grant_t grant_ff;
	nei_grant_t nxt_grant;
	logic       wake_ff;

	always_ff @(posedge REF_CLK_IN) begin
		// Sampling keeps running in reset so a held-high pin stays visible
		nmi_s1_ff <= NMI_PIN_IN;
		nmi_s2_ff <= nmi_s1_ff;
	end

	assign nmi_rise = nmi_s1_ff & ~nmi_s2_ff;

	// ----------------------------------------
	// Pending register
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			// Pin high in reset makes pending at release
			pend_ff <= `NEI_PEND_RESET;
			pend_ff[`NEI_PEND_NMI_BIT] <= NMI_PIN_IN;
		end else begin
			if (PEND_WR_IN) begin
				pend_ff <= PEND_WR_DATA_IN;
			end
			// Set wins over a clear in the same cycle
			if (nmi_rise || (rst_d_ff && nmi_s1_ff)) begin
				pend_ff[`NEI_PEND_NMI_BIT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Reset release strap capture
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN) begin
		rst_d_ff <= RESET_IN;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			isolate_ff <= 1'b0;
		end else if (rst_d_ff) begin
			// Caught on the first edge after release, held until next reset
			isolate_ff <= EMULATION_ISOLATE_STRAP_IN;
		end
	end

	// ----------------------------------------
	// Power mode
	// ----------------------------------------
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			NEI_MODE_RUN: begin
				if (MODE_REQ_VALID_IN) begin
					nxt_mode = MODE_REQ_IN;
				end
			end
			NEI_MODE_IDLE: begin
				if (nmi_rise) begin
					nxt_mode = NEI_MODE_RUN;
				end
			end
			NEI_MODE_STBY: begin
				nxt_mode = NEI_MODE_STBY;
			end
			NEI_MODE_PDOWN: begin
				nxt_mode = NEI_MODE_PDOWN;
			end
			default: begin
				nxt_mode = NEI_MODE_RUN;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			mode_ff <= NEI_MODE_RUN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= (mode_ff == NEI_MODE_IDLE) && nmi_rise;
		end
	end

	// ----------------------------------------
	// Priority
	// ----------------------------------------
	always_comb begin
		nxt_grant = '0;
		if (REQ_IN.trap) begin
			nxt_grant = '{valid: 1'b1, src: NEI_SRC_TRAP};
		end else if (REQ_IN.unimpl) begin
			nxt_grant = '{valid: 1'b1, src: NEI_SRC_UNIMPL};
		end else if (pend_ff[`NEI_PEND_NMI_BIT]) begin
			nxt_grant = '{valid: 1'b1, src: NEI_SRC_NMI};
		end else if (REQ_IN.other) begin
			nxt_grant = '{valid: 1'b1, src: NEI_SRC_OTHER};
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			grant_ff <= '0;
		end else begin
			grant_ff <= nxt_grant;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Kept pins are inputs here, so the core enables float as a group
	assign PIN_OE_OUT = isolate_ff ? '0 : PIN_OE_CORE_IN;
	assign NMI_PENDING_OUT = pend_ff[`NEI_PEND_NMI_BIT];
	assign INTERRUPT_PENDING_REG_HI_OUT = pend_ff;
	assign GRANT_OUT = grant_ff;
	assign WAKE_OUT = wake_ff;
	assign MODE_OUT = mode_ff;
	assign ISOLATE_OUT = isolate_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_rise;
		!nmi_s2_ff && nmi_s1_ff;
	endsequence

	property p_rise_sets;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		s_rise |=> NMI_PENDING_OUT;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("edge did not set pending");

	property p_prio;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(NMI_PENDING_OUT && !REQ_IN.trap && !REQ_IN.unimpl) |=> GRANT_OUT.src == NEI_SRC_NMI;
	endproperty
	a_prio: assert property (p_prio) else $error("nmi grant order wrong");

	property p_reset_pend;
		@(posedge REF_CLK_IN)
		(RESET_IN && NMI_PIN_IN) |=> NMI_PENDING_OUT;
	endproperty
	a_reset_pend: assert property (p_reset_pend) else $error("held pin not pending");

	property p_hold;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(NMI_PENDING_OUT && !PEND_WR_IN) |=> NMI_PENDING_OUT;
	endproperty
	a_hold: assert property (p_hold) else $error("pending dropped");

	property p_clear;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(PEND_WR_IN && !PEND_WR_DATA_IN[7] && !nmi_s1_ff && !rst_d_ff) |=> !NMI_PENDING_OUT;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	property p_wake;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(MODE_OUT == NEI_MODE_IDLE) ##0 s_rise |=> (WAKE_OUT && MODE_OUT == NEI_MODE_RUN);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from idle");

	property p_strap;
		@(posedge REF_CLK_IN)
		($fell(RESET_IN) ##0 !RESET_IN) |=> ISOLATE_OUT == $past(EMULATION_ISOLATE_STRAP_IN);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not captured");

	property p_float;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		ISOLATE_OUT |-> PIN_OE_OUT == '0;
	endproperty
	a_float: assert property (p_float) else $error("pin driven in isolation");

	property p_stay;
		@(posedge REF_CLK_IN)
		(ISOLATE_OUT && !RESET_IN) |=> (ISOLATE_OUT || $past(RESET_IN));
	endproperty
	a_stay: assert property (p_stay) else $error("isolation left without reset");

	property p_reset_mode;
		@(posedge REF_CLK_IN)
		RESET_IN |=> MODE_OUT == NEI_MODE_RUN;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("reset kept low power mode");

endmodule : nei_top

// File: verif/nei_ext_drv.sv
`include "nei_defs.svh"

module nei_ext_drv
	import nei_pkg::*;
(
	// Clock
	input  wire logic clk_in,
	// Pins toward the device
	output logic      nmi_pin_out,
	output logic      strap_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// System side, strap grounded by default
	// ----------------------------------------
	initial begin
		nmi_pin_out = 1'b0;
		strap_out   = 1'b0;
	end

	task automatic set_pin(input logic v);
		nmi_pin_out = v;
	endtask : set_pin

	// Held steady across the reset release edge
	task automatic set_strap(input logic v);
		strap_out = v;
	endtask : set_strap

	// Short pulses would be missed, so stretch past one state time
	task automatic nmi_pulse(input int hold);
		int n;
		n = (hold > `NEI_STATE_CYCLES) ? hold : `NEI_STATE_CYCLES + 1;
		nmi_pin_out = 1'b1;
		repeat (n) @(posedge clk_in);
		#1;
		nmi_pin_out = 1'b0;
	endtask : nmi_pulse
endmodule : nei_ext_drv

// File: verif/tb_nmi_and_emulation_isolation.sv
`include "nei_defs.svh"

module tb_nmi_and_emulation_isolation
	import nei_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk, rst, pin, strap, mvld, pwr;
	nei_req_t    req;
	nei_mode_t   mreq, mode;
	logic [7:0]  pwd, preg;
	logic [31:0] core_oe, oe;
	logic        pend, wake, iso;
	nei_grant_t  gnt;
	int          n_fail, tests_run, cyc;

	nei_ext_drv drv (.clk_in(clk), .nmi_pin_out(pin), .strap_out(strap));

	nei_top dut (
		.REF_CLK_IN(clk), .RESET_IN(rst), .NMI_PIN_IN(pin),
		.EMULATION_ISOLATE_STRAP_IN(strap), .REQ_IN(req), .MODE_REQ_IN(mreq),
		.MODE_REQ_VALID_IN(mvld), .PEND_WR_IN(pwr), .PEND_WR_DATA_IN(pwd),
		.PIN_OE_CORE_IN(core_oe), .NMI_PENDING_OUT(pend),
		.INTERRUPT_PENDING_REG_HI_OUT(preg), .GRANT_OUT(gnt), .WAKE_OUT(wake),
		.MODE_OUT(mode), .ISOLATE_OUT(iso), .PIN_OE_OUT(oe));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic do_reset(input logic s, input logic p);
		rst = 1'b1;
		drv.set_strap(s);
		drv.set_pin(p);
		step(4);
		rst = 1'b0;
		step(2);
	endtask : do_reset

	task automatic wr_pend(input logic [7:0] d);
		pwr = 1'b1;
		pwd = d;
		step(1);
		pwr = 1'b0;
		step(1);
	endtask : wr_pend

	task automatic set_mode(input nei_mode_t m);
		mvld = 1'b1;
		mreq = m;
		step(1);
		mvld = 1'b0;
		step(1);
	endtask : set_mode

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_edge();
		chk(preg, 8'h00);
		drv.nmi_pulse(3);
		chk(pend, 1'b1);
		wr_pend(8'hc3);
		chk(preg, 8'hc3);
		wr_pend(8'h43);
		chk({preg, 7'h00, pend}, 16'h4300);
		// Clear lands on the edge that sees the rise
		fork
			drv.nmi_pulse(3);
			begin
				step(1);
				wr_pend(8'h00);
			end
		join
		chk(preg, 8'h80);
		wr_pend(8'h00);
		$display("edge test done");
	endtask : t_edge

	task automatic t_prio();
		drv.nmi_pulse(4);
		req = '{trap: 1'b1, unimpl: 1'b1, other: 1'b1};
		step(2);
		chk(gnt, {1'b1, NEI_SRC_TRAP});
		req.trap = 1'b0;
		step(2);
		chk(gnt, {1'b1, NEI_SRC_UNIMPL});
		req.unimpl = 1'b0;
		step(2);
		chk(gnt, {1'b1, NEI_SRC_NMI});
		wr_pend(8'h00);
		step(1);
		chk(gnt, {1'b1, NEI_SRC_OTHER});
		req = '0;
		$display("priority test done");
	endtask : t_prio

	task automatic t_idle();
		int seen;
		seen = 0;
		set_mode(NEI_MODE_IDLE);
		chk(mode, NEI_MODE_IDLE);
		fork
			drv.nmi_pulse(3);
			repeat (6) begin
				step(1);
				if (wake === 1'b1)
					seen++;
			end
		join
		chk(seen, 1);
		chk({mode, pend}, {NEI_MODE_RUN, 1'b1});
		wr_pend(8'h00);
		$display("idle test done");
	endtask : t_idle

	task automatic t_stby();
		set_mode(NEI_MODE_PDOWN);
		chk(mode, NEI_MODE_PDOWN);
		do_reset(1'b0, 1'b0);
		chk(mode, NEI_MODE_RUN);
		set_mode(NEI_MODE_STBY);
		chk(mode, NEI_MODE_STBY);
		do_reset(1'b0, 1'b1);
		chk(mode, NEI_MODE_RUN);
		chk(preg, 8'h80);
		drv.set_pin(1'b0);
		wr_pend(preg & `NEI_PEND_CLR_MASK);
		chk(pend, 1'b0);
		$display("standby test done");
	endtask : t_stby

	task automatic t_iso();
		chk(oe, core_oe);
		do_reset(1'b1, 1'b0);
		chk(iso, 1'b1);
		chk(oe, 32'h0);
		drv.set_strap(1'b0);
		step(4);
		chk(iso, 1'b1);
		do_reset(1'b0, 1'b0);
		chk(iso, 1'b0);
		chk(oe, core_oe);
		$display("isolation test done");
	endtask : t_iso

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n_fail = 0;
		tests_run = 0;
		cyc = 0;
		rst = 1'b1;
		mvld = 1'b0;
		pwr = 1'b0;
		pwd = 8'h00;
		req = '0;
		mreq = NEI_MODE_RUN;
		core_oe = 32'ha5a5_c3c3;
		do_reset(1'b0, 1'b0);
		t_edge();
		t_prio();
		t_idle();
		t_stby();
		t_iso();
		give_verdict();
	end
endmodule : tb_nmi_and_emulation_isolation
